// ---- design/rnl_pin_select.sv ----
// Channel 1 shared receive pin selector with APB control, alarm capture and violation counters.
`timescale 1ns/1ps
`default_nettype none
module rnl_pin_select
  import rnl_pkg::*;
#(
  parameter int CNT_W = RNL_CNT_W
) (
  input  wire logic                  MCLK,
  input  wire logic                  RESET_N,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [RNL_ADDR_W-1:0] PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  RX_SHARED_PIN_CH1,
  input  wire logic                  RX_TRIBUTARY_LINE_CLOCK_CH1,
  output logic                       PATH_AIS_DEFECT_CH1,
  output logic                       RX_NEGATIVE_RAIL_OUT_CH1,
  output logic                       RX_NEGATIVE_RAIL_VALID_CH1,
  output logic                       RX_CODE_VIOLATION_EVENT_CH1
);

  // Synchronised views of the pin and the line clock.
  logic shared_pin_s;
  logic line_clk_s;
  logic smp_stb;
  logic smp_val;

  rnl_sync3 u_sync_pin (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     (RX_SHARED_PIN_CH1),
    .q     (shared_pin_s)
  );

  rnl_sync3 u_sync_lclk (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     (RX_TRIBUTARY_LINE_CLOCK_CH1),
    .q     (line_clk_s)
  );

  // Control register state.
  logic [RNL_CTRL_W-1:0] ctrl_r;
  logic [RNL_CTRL_W-1:0] ctrl_nxt;
  logic                  tbus_en;
  rnl_mode_e             mode;
  logic                  fall_sel;
  logic                  count_exz;

  always_comb begin
    tbus_en   = ctrl_r[RNL_CTRL_TBUS];
    mode      = rnl_mode_e'(ctrl_r[RNL_CTRL_MODE_H:RNL_CTRL_MODE_L]);
    fall_sel  = ctrl_r[RNL_CTRL_EDGE];
    count_exz = ctrl_r[RNL_CTRL_CSEL];
  end

  rnl_edge_sampler u_sampler (
    .clk      (MCLK),
    .rst_n    (RESET_N),
    .line_clk (line_clk_s),
    .data     (shared_pin_s),
    .fall_sel (fall_sel),
    .smp_stb  (smp_stb),
    .smp_val  (smp_val)
  );

  // Role decode of the shared pin.
  logic role_alarm;
  logic role_lcv;
  logic role_neg;

  always_comb begin
    role_alarm = tbus_en;
    role_lcv   = 1'b0;
    role_neg   = 1'b0;
    if (!tbus_en) begin
      unique case (mode)
        RNL_MODE_SINGLE: role_lcv = 1'b1;
        RNL_MODE_DUAL:   role_neg = 1'b1;
        default:         ; // STS-1 mode and the unused code leave the pin ignored.
      endcase
    end
  end

  // APB decode.
  logic setup_ph;
  logic access_ph;
  logic wr_acc;
  logic addr_ok;

  function automatic logic is_mapped(input logic [RNL_ADDR_W-1:0] a);
    is_mapped = (a == RNL_OFS_CTRL) || (a == RNL_OFS_STATUS) ||
                (a == RNL_OFS_LCV_CNT) || (a == RNL_OFS_EXZ_CNT);
  endfunction : is_mapped

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic en);
    sat_inc = (en && (v != {CNT_W{1'b1}})) ? v + {{(CNT_W-1){1'b0}}, 1'b1} : v;
  endfunction : sat_inc

  always_comb begin
    setup_ph  = PSEL && !PENABLE;
    access_ph = PSEL && PENABLE;
    addr_ok   = is_mapped(PADDR);
    wr_acc    = access_ph && PWRITE && addr_ok;
  end

  // Alarm edge, defect flag, counters and rail outputs.
  logic             alarm_d_r;
  logic             alarm_d_nxt;
  logic             ais_r;
  logic             ais_nxt;
  logic [CNT_W-1:0] lcv_cnt_r;
  logic [CNT_W-1:0] lcv_cnt_nxt;
  logic [CNT_W-1:0] exz_cnt_r;
  logic [CNT_W-1:0] exz_cnt_nxt;
  logic             neg_r;
  logic             neg_nxt;
  logic             neg_vld_r;
  logic             neg_vld_nxt;
  logic             lcv_ev_r;
  logic             lcv_ev_nxt;
  logic [31:0]      prdata_r;
  logic [31:0]      prdata_nxt;
  logic             alarm_rise;
  logic             lcv_hit;

  always_comb begin
    alarm_rise  = role_alarm && shared_pin_s && !alarm_d_r;
    lcv_hit     = role_lcv && smp_stb && smp_val;
    alarm_d_nxt = shared_pin_s;
    ctrl_nxt    = ctrl_r;
    ais_nxt     = ais_r;
    lcv_cnt_nxt = lcv_cnt_r;
    exz_cnt_nxt = exz_cnt_r;
    if (wr_acc && (PADDR == RNL_OFS_CTRL)) begin
      ctrl_nxt = PWDATA[RNL_CTRL_W-1:0];
    end
    if (wr_acc && (PADDR == RNL_OFS_STATUS) && PWDATA[RNL_STAT_AIS]) begin
      ais_nxt = 1'b0;
    end
    if (alarm_rise) begin
      ais_nxt = 1'b1;
    end
    // A write clears a counter; an event in the same cycle still counts as one.
    if (wr_acc && (PADDR == RNL_OFS_LCV_CNT)) begin
      lcv_cnt_nxt = '0;
    end
    if (wr_acc && (PADDR == RNL_OFS_EXZ_CNT)) begin
      exz_cnt_nxt = '0;
    end
    lcv_cnt_nxt = sat_inc(lcv_cnt_nxt, lcv_hit && !count_exz);
    exz_cnt_nxt = sat_inc(exz_cnt_nxt, lcv_hit && count_exz);
    lcv_ev_nxt  = lcv_hit;
    neg_vld_nxt = role_neg && smp_stb;
    neg_nxt     = (role_neg && smp_stb) ? smp_val : neg_r;
    prdata_nxt  = prdata_r;
    if (setup_ph && !PWRITE) begin
      prdata_nxt = 32'h0000_0000;
      if (PADDR == RNL_OFS_CTRL) begin
        prdata_nxt[RNL_CTRL_W-1:0] = ctrl_r;
      end
      if (PADDR == RNL_OFS_STATUS) begin
        prdata_nxt[RNL_STAT_AIS] = ais_r;
        prdata_nxt[RNL_STAT_PIN] = shared_pin_s;
      end
      if (PADDR == RNL_OFS_LCV_CNT) begin
        prdata_nxt[CNT_W-1:0] = lcv_cnt_r;
      end
      if (PADDR == RNL_OFS_EXZ_CNT) begin
        prdata_nxt[CNT_W-1:0] = exz_cnt_r;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ctrl_r    <= RNL_CTRL_RESET;
      alarm_d_r <= 1'b0;
      ais_r     <= 1'b0;
      lcv_cnt_r <= '0;
      exz_cnt_r <= '0;
      neg_r     <= 1'b0;
      neg_vld_r <= 1'b0;
      lcv_ev_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      alarm_d_r <= alarm_d_nxt;
      ais_r     <= ais_nxt;
      lcv_cnt_r <= lcv_cnt_nxt;
      exz_cnt_r <= exz_cnt_nxt;
      neg_r     <= neg_nxt;
      neg_vld_r <= neg_vld_nxt;
      lcv_ev_r  <= lcv_ev_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // Read data is captured in the setup cycle, so the slave never needs wait states.
  assign PREADY                      = 1'b1;
  assign PSLVERR                     = access_ph && !addr_ok;
  assign PRDATA                      = prdata_r;
  assign PATH_AIS_DEFECT_CH1         = ais_r;
  assign RX_NEGATIVE_RAIL_OUT_CH1    = neg_r;
  assign RX_NEGATIVE_RAIL_VALID_CH1  = neg_vld_r;
  assign RX_CODE_VIOLATION_EVENT_CH1 = lcv_ev_r;

  // Checks.
  sequence s_alarm_edge;
    tbus_en && shared_pin_s && !alarm_d_r;
  endsequence

  sequence s_lcv_sample;
    !tbus_en && (mode == RNL_MODE_SINGLE) && smp_stb && smp_val && !count_exz && !wr_acc;
  endsequence

  sequence s_exz_sample;
    !tbus_en && (mode == RNL_MODE_SINGLE) && smp_stb && smp_val && count_exz && !wr_acc;
  endsequence

  sequence s_ais_clear;
    wr_acc && (PADDR == RNL_OFS_STATUS) && PWDATA[RNL_STAT_AIS] && !(tbus_en && shared_pin_s && !alarm_d_r);
  endsequence

  a_ais_declare: assert property (@(posedge MCLK) disable iff (!RESET_N)
      s_alarm_edge |=> PATH_AIS_DEFECT_CH1 ##1 (PATH_AIS_DEFECT_CH1 || $past(wr_acc, 1)))
    else $error("Alarm pulse did not declare path AIS.");

  a_ais_source: assert property (@(posedge MCLK) disable iff (!RESET_N)
      $rose(ais_r) |-> $past(tbus_en, 1) && $past(shared_pin_s, 1))
    else $error("Path AIS raised without an alarm in telecom bus role.");

  a_lcv_count: assert property (@(posedge MCLK) disable iff (!RESET_N)
      s_lcv_sample ##0 (lcv_cnt_r != {CNT_W{1'b1}}) |=> lcv_cnt_r == $past(lcv_cnt_r, 1) + 1'b1)
    else $error("Violation counter did not step on a sampled violation.");

  a_lcv_event: assert property (@(posedge MCLK) disable iff (!RESET_N)
      RX_CODE_VIOLATION_EVENT_CH1 |-> $past(role_lcv, 1) && $past(smp_stb, 1) && $past(smp_val, 1))
    else $error("Violation event outside single-rail sampling.");

  a_sts1_quiet: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (!tbus_en && (mode == RNL_MODE_STS1) && !wr_acc) ##1 !wr_acc |->
      $stable(lcv_cnt_r) && $stable(exz_cnt_r) && !RX_NEGATIVE_RAIL_VALID_CH1)
    else $error("Pin acted on in STS-1 mode.");

  a_neg_data: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (role_neg && smp_stb) |=> RX_NEGATIVE_RAIL_VALID_CH1 && (RX_NEGATIVE_RAIL_OUT_CH1 == $past(smp_val, 1)))
    else $error("Negative rail sample not passed on.");

  // Counter checks skip cycles with a bus write, since a write to a counter offset clears that counter.
  a_exz_count: assert property (@(posedge MCLK) disable iff (!RESET_N)
      s_exz_sample ##0 (exz_cnt_r != {CNT_W{1'b1}}) |=> exz_cnt_r == $past(exz_cnt_r, 1) + 1'b1)
    else $error("Excess-zeros counter did not step on a sampled violation.");

  a_lcv_steer: assert property (@(posedge MCLK) disable iff (!RESET_N)
      s_lcv_sample |=> $stable(exz_cnt_r))
    else $error("Violation reached the excess-zeros counter.");

  a_exz_steer: assert property (@(posedge MCLK) disable iff (!RESET_N)
      s_exz_sample |=> $stable(lcv_cnt_r))
    else $error("Violation reached the violation counter.");

  a_lcv_zero: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (role_lcv && smp_stb && !smp_val && !wr_acc) |=>
      !RX_CODE_VIOLATION_EVENT_CH1 && $stable(lcv_cnt_r) && $stable(exz_cnt_r))
    else $error("A clean sample was counted as a violation.");

  a_ais_sticky: assert property (@(posedge MCLK) disable iff (!RESET_N)
      (ais_r && !(wr_acc && (PADDR == RNL_OFS_STATUS) && PWDATA[RNL_STAT_AIS])) |=> PATH_AIS_DEFECT_CH1)
    else $error("Path AIS dropped without a clear.");

  a_ais_clear: assert property (@(posedge MCLK) disable iff (!RESET_N)
      s_ais_clear |=> !PATH_AIS_DEFECT_CH1)
    else $error("Path AIS not cleared by a status write.");

  a_alarm_quiet: assert property (@(posedge MCLK) disable iff (!RESET_N)
      tbus_en |=> !RX_CODE_VIOLATION_EVENT_CH1 && !RX_NEGATIVE_RAIL_VALID_CH1)
    else $error("Line role output active in telecom bus role.");

  a_single_no_rail: assert property (@(posedge MCLK) disable iff (!RESET_N)
      role_lcv |=> !RX_NEGATIVE_RAIL_VALID_CH1)
    else $error("Negative rail valid in single-rail role.");

  a_rail_role: assert property (@(posedge MCLK) disable iff (!RESET_N)
      RX_NEGATIVE_RAIL_VALID_CH1 |-> $past(role_neg, 1))
    else $error("Negative rail valid outside dual-rail role.");

  a_neg_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
      !(role_neg && smp_stb) |=> $stable(RX_NEGATIVE_RAIL_OUT_CH1))
    else $error("Negative rail bit changed without a sample.");

  a_event_pulse: assert property (@(posedge MCLK) disable iff (!RESET_N)
      RX_CODE_VIOLATION_EVENT_CH1 |=> !RX_CODE_VIOLATION_EVENT_CH1)
    else $error("Violation event longer than one cycle.");

  a_rail_pulse: assert property (@(posedge MCLK) disable iff (!RESET_N)
      RX_NEGATIVE_RAIL_VALID_CH1 |=> !RX_NEGATIVE_RAIL_VALID_CH1)
    else $error("Negative rail valid longer than one cycle.");

  a_rdata_hold: assert property (@(posedge MCLK) disable iff (!RESET_N)
      !(setup_ph && !PWRITE) |=> $stable(PRDATA))
    else $error("Read data changed outside a read setup cycle.");

endmodule : rnl_pin_select
`default_nettype wire

// ---- design/rnl_pkg.sv ----
// Constants, modes and register layout for the channel 1 shared receive pin selector.
// Behaviour
// - Pin role follows telecom bus enable, then the tributary mode of the channel.
// - An alarm pulse with the telecom bus enabled declares path AIS with no software action.
// - Single-rail mode with telecom bus off: the pin is the line code violation input.
// - Single-rail mode samples the violation input on the chosen line clock edge.
// - Single-rail mode counts sampled violations into the violation or excess-zeros counter.
package rnl_pkg;

  typedef enum logic [1:0] {
    RNL_MODE_STS1   = 2'b00,
    RNL_MODE_SINGLE = 2'b01,
    RNL_MODE_DUAL   = 2'b10
  } rnl_mode_e;

  localparam int          RNL_ADDR_W      = 8;
  localparam int          RNL_CNT_W       = 16;
  localparam logic [7:0]  RNL_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  RNL_OFS_STATUS  = 8'h04;
  localparam logic [7:0]  RNL_OFS_LCV_CNT = 8'h08;
  localparam logic [7:0]  RNL_OFS_EXZ_CNT = 8'h0C;

  localparam int          RNL_CTRL_TBUS   = 0;
  localparam int          RNL_CTRL_MODE_L = 1;
  localparam int          RNL_CTRL_MODE_H = 2;
  localparam int          RNL_CTRL_EDGE   = 3;
  localparam int          RNL_CTRL_CSEL   = 4;
  localparam int          RNL_CTRL_W      = 5;
  localparam logic [4:0]  RNL_CTRL_RESET  = 5'h00;

  localparam int          RNL_STAT_AIS    = 0;
  localparam int          RNL_STAT_PIN    = 1;

endpackage : rnl_pkg

// ---- design/rnl_sync3.sv ----
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module rnl_sync3 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       q_r;
  logic       q_nxt;

  // Stage one feeds only stage two, so a metastable value never reaches the compare.
  always_comb begin
    sh_nxt = {sh_r[1:0], d};
    q_nxt  = (sh_r[1] == sh_r[2]) ? sh_r[2] : q_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_r <= 3'h0;
      q_r  <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      q_r  <= q_nxt;
    end
  end

  assign q = q_r;
endmodule : rnl_sync3
`default_nettype wire

// ---- design/rnl_edge_sampler.sv ----
// Samples the synchronised shared pin on the selected edge of the synchronised line clock.
`timescale 1ns/1ps
`default_nettype none
module rnl_edge_sampler (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic line_clk,
  input  wire logic data,
  input  wire logic fall_sel,
  output logic      smp_stb,
  output logic      smp_val
);
  logic lclk_r;
  logic lclk_nxt;
  logic stb_r;
  logic stb_nxt;
  logic val_r;
  logic val_nxt;
  logic hit;

  always_comb begin
    hit      = fall_sel ? (lclk_r && !line_clk) : (!lclk_r && line_clk);
    lclk_nxt = line_clk;
    stb_nxt  = hit;
    val_nxt  = hit ? data : val_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lclk_r <= 1'b0;
      stb_r  <= 1'b0;
      val_r  <= 1'b0;
    end else begin
      lclk_r <= lclk_nxt;
      stb_r  <= stb_nxt;
      val_r  <= val_nxt;
    end
  end

  assign smp_stb = stb_r;
  assign smp_val = val_r;

  a_edge_sense: assert property (@(posedge clk) disable iff (!rst_n)
      smp_stb |-> ($past(fall_sel, 1) ? ($past(lclk_r, 1) && !$past(line_clk, 1))
                                      : (!$past(lclk_r, 1) && $past(line_clk, 1))))
    else $error("Sample strobe not on the selected line clock edge.");
endmodule : rnl_edge_sampler
`default_nettype wire

// ---- testbench/rnl_liu_model.sv ----
// Far-side model: telecom bus alarm source or line interface unit driving the shared pin.
`timescale 1ns/1ps
`default_nettype none
module rnl_liu_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic alarm,
  input  wire logic sts,
  input  wire logic fall,
  input  wire logic bit_in,
  output logic      pin,
  output logic      lclk,
  output logic      busy
);
  // The line clock stands still between frames. The bit is valid only around the selected edge and
  // shows its inverse around the other one, so a sample on the wrong edge reads the wrong value.
  initial begin
    pin  = 1'b0;
    lclk = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go && !busy) begin
        busy <= 1'b1;
        if (alarm) begin
          pin <= 1'b1;
          repeat (6) @(posedge clk);
          pin <= 1'b0;
        end else begin
          pin <= sts ? 1'b0 : (bit_in ^ fall);
          repeat (6) @(posedge clk);
          lclk <= 1'b1;
          repeat (4) @(posedge clk);
          pin <= sts ? 1'b0 : (bit_in ^ !fall);
          repeat (4) @(posedge clk);
          lclk <= 1'b0;
          repeat (8) @(posedge clk);
          // Once hold time is over the bit is no longer valid, so show its inverse.
          pin <= sts ? 1'b0 : ~bit_in;
        end
        repeat (8) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule : rnl_liu_model
`default_nettype wire

// ---- testbench/rnl_pin_select_bench.sv ----
// Self-checking bench for the channel 1 shared receive pin selector.
`timescale 1ns/1ps
`default_nettype none
module rnl_pin_select_bench;
  import rnl_pkg::*;
  logic        mclk, reset_n, psel, penable, pwrite, go, alarm, sts, fall, bit_v, pin, lclk, busy, b, er;
  logic        pready, pslverr, ais, nrail, nvalid, cv_ev;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  notes[$];
  logic [31:0] ctl[5] = '{32'h0000_0002, 32'h0000_001A, 32'h0000_0004, 32'h0000_0000, 32'h0000_0006};
  int          fail_count, n_checks, cycles, ones;

  rnl_pin_select DUT (.MCLK(mclk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_SHARED_PIN_CH1(pin), .RX_TRIBUTARY_LINE_CLOCK_CH1(lclk), .PATH_AIS_DEFECT_CH1(ais),
    .RX_NEGATIVE_RAIL_OUT_CH1(nrail), .RX_NEGATIVE_RAIL_VALID_CH1(nvalid), .RX_CODE_VIOLATION_EVENT_CH1(cv_ev));
  rnl_liu_model far (.clk(mclk), .go(go), .alarm(alarm), .sts(sts), .fall(fall), .bit_in(bit_v), .pin(pin),
    .lclk(lclk), .busy(busy));

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  task bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) bad(m);
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    if (pready !== 1'b1) bad("bus timeout");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task frame(input logic v, input logic a);
    int n;
    n = 0;
    go <= 1'b1; bit_v <= v; alarm <= a;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
    while (busy === 1'b1 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    if (busy === 1'b1) bad("frame timeout");
  endtask : frame

  // Every pulse must match the oldest expectation; a pulse with none pending is a fault.
  always @(posedge mclk) begin
    if (cv_ev === 1'b1 || nvalid === 1'b1) begin
      n_checks++;
      if (notes.size() == 0) bad("unexpected pulse");
      else if (notes.pop_front() !== {cv_ev, nvalid, nvalid & nrail}) bad("pulse mismatch");
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad("timeout");
      end_sim();
    end
  end

  initial begin
    {reset_n, psel, penable, pwrite, go, alarm, sts, fall, bit_v} = '0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(97));
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk({pready, pslverr, ais, nrail, nvalid, cv_ev}, 32'h0000_0020, "reset outputs");
    chk(prdata, '0, "reset read data");
    apb(1'b0, RNL_OFS_CTRL, '0);
    chk(rd, '0, "ctrl reset");
    apb(1'b0, 8'h10, '0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, '0, "unmapped read");
    // The last pass uses the unused mode code: the pin toggles with line clock edges and must be ignored.
    for (int i = 0; i < 5; i++) begin
      sts <= (i == 3);
      fall <= ctl[i][RNL_CTRL_EDGE];
      apb(1'b1, RNL_OFS_CTRL, ctl[i]);
      apb(1'b0, RNL_OFS_CTRL, '0);
      chk(rd, ctl[i], "ctrl readback");
      ones = 0;
      repeat (4) begin
        b = 1'($urandom_range(1));
        if (i < 2 && b) begin
          notes.push_back(3'b100);
          ones++;
        end
        if (i == 2) notes.push_back({2'b01, b});
        frame(b, 1'b0);
      end
      if (i < 2) begin
        apb(1'b0, i ? RNL_OFS_EXZ_CNT : RNL_OFS_LCV_CNT, '0);
        chk(rd, ones, "violation count");
      end
    end
    frame(1'b0, 1'b1);
    chk(ais, 1'b0, "ais with bus off");
    sts <= 1'b0;
    apb(1'b1, RNL_OFS_CTRL, 32'h0000_0001);
    frame(1'b0, 1'b1);
    chk(ais, 1'b1, "ais set");
    apb(1'b0, RNL_OFS_STATUS, '0);
    chk(rd, 32'h0000_0001, "ais status");
    apb(1'b1, RNL_OFS_STATUS, 32'h0000_0001);
    chk(ais, 1'b0, "ais clear");
    chk(notes.size(), 0, "pulses missing");
    end_sim();
  end
endmodule : rnl_pin_select_bench
`default_nettype wire
